// ### core/eprg_map.vh
// Purpose: constants for the byte-programming sequencer of a one-time-programmable memory
// Assumes: core_clk at 250 MHz (4 ns period)
// Notes: times in ns, cycle counts derived from them
// How it works
// - program mode needs high supply raised, chip select and pulse low
// - byte presented as eight parallel bits on data pins during programming
// - pulses of 95 to 105 us, verify after each, repeat until match; code gives up after EPRG_MAX_TRIES pulses
// - no extra pulse after a good verify; go straight to next byte
// - parallel devices share inputs; each chip select driven separately
// - address, data and chip select stable 2 us before pulse falls
// - programming and core supplies raised 2 us before pulse falls
// - data held 2 us after pulse returns high
// - wait 2 us before output gate low; hold address until gate high
// - verify with chip select and gate low, pulse high, supply raised
`ifndef EPRG_MAP_VH
`define EPRG_MAP_VH

`define EPRG_CLK_PERIOD_NS 4
`define EPRG_SETUP_NS 2000
`define EPRG_PULSE_NOM_NS 100000
`define EPRG_HOLD_NS 2000
`define EPRG_GATE_ACCESS_NS 100
`define EPRG_GATE_FLOAT_NS 130
// least times round up
`define EPRG_SETUP_CYC ((`EPRG_SETUP_NS + `EPRG_CLK_PERIOD_NS - 1) / `EPRG_CLK_PERIOD_NS)
`define EPRG_HOLD_CYC ((`EPRG_HOLD_NS + `EPRG_CLK_PERIOD_NS - 1) / `EPRG_CLK_PERIOD_NS)
`define EPRG_ACCESS_CYC ((`EPRG_GATE_ACCESS_NS + `EPRG_CLK_PERIOD_NS - 1) / `EPRG_CLK_PERIOD_NS)
`define EPRG_FLOAT_CYC ((`EPRG_GATE_FLOAT_NS + `EPRG_CLK_PERIOD_NS - 1) / `EPRG_CLK_PERIOD_NS)
// nominal pulse sits inside the 95..105 us window
`define EPRG_PULSE_CYC (`EPRG_PULSE_NOM_NS / `EPRG_CLK_PERIOD_NS)
`define EPRG_ERASED_BYTE 8'hff
`define EPRG_MAX_TRIES 25

`endif

// ### core/eprg_fifo.v
// Purpose: small synchronous fifo for address/data requests
// Assumes: single clock, synchronous active-low reset
// Notes: read data registered; honest full and empty
`timescale 1ns/1ps
module eprg_fifo #(
    parameter WIDTH = 25,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clocking
    input wire core_clk,
    input wire rstn,
    input wire ce,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // output register is a slot beyond DEPTH, so pop refills it
    // no ready while frozen, else a push at that edge would be lost
    assign in_ready = ce && (count < DEPTH);
    assign push = in_valid && in_ready;
    assign pop = (!out_valid || out_ready) && (count != 0);

    always @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                out_data <= mem[rd_ptr];
                rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule

// ### core/eprg_prog.v
// Purpose: host-side sequencer that programs bytes into an otp memory through its pins
// Assumes: pins sampled synchronously to core_clk; supplies switched by external regulators
// Notes: one byte per request; pulse, verify, retry until match or try limit
`timescale 1ns/1ps
`include "eprg_map.vh"
module eprg_prog #(
    parameter ADDR_W = 17,
    parameter NDEV = 1,
    parameter MAX_TRIES = `EPRG_MAX_TRIES,
    parameter PULSE_CYC = `EPRG_PULSE_CYC,
    parameter FIFO_DEPTH = 4
) (
    // clocking
    input wire core_clk,
    input wire rstn,
    input wire ce,
    // request stream
    input wire req_valid,
    output wire req_ready,
    input wire [ADDR_W-1:0] req_addr,
    input wire [7:0] req_data,
    input wire [NDEV-1:0] req_sel,
    // result
    output reg done,
    output reg fail,
    output reg [7:0] tries,
    output reg busy,
    // memory pins
    output reg [ADDR_W-1:0] mem_addr,
    output reg [7:0] mem_data_out,
    output reg mem_data_oe,
    input wire [7:0] mem_data_in,
    output reg [NDEV-1:0] chip_select_n,
    output reg output_gate_n,
    output reg write_pulse_n,
    output reg vpp_high,
    output reg vcc_prog
);
    localparam RW = ADDR_W + 8 + NDEV;
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_SETUP = 7'h02;
    localparam [6:0] S_PULSE = 7'h04;
    localparam [6:0] S_HOLD = 7'h08;
    localparam [6:0] S_GATE = 7'h10;
    localparam [6:0] S_FLOAT = 7'h20;
    localparam [6:0] S_GAP = 7'h40;
    // integer constants cut to the counter widths on purpose
    localparam [31:0] SETUP_W = `EPRG_SETUP_CYC;
    localparam [31:0] HOLD_W = `EPRG_HOLD_CYC;
    localparam [31:0] ACC_W = `EPRG_ACCESS_CYC;
    localparam [31:0] FLT_W = `EPRG_FLOAT_CYC;
    localparam [31:0] PLS_W = PULSE_CYC;
    localparam [31:0] TRY_W = MAX_TRIES;
    localparam [16:0] SETUP_C = SETUP_W[16:0];
    localparam [16:0] HOLD_C = HOLD_W[16:0];
    localparam [16:0] ACC_C = ACC_W[16:0];
    localparam [16:0] FLT_C = FLT_W[16:0];
    localparam [16:0] PLS_C = PLS_W[16:0];
    localparam [7:0] TRY_LIM = TRY_W[7:0];

    reg [6:0] state;
    reg [16:0] cnt;
    reg [7:0] want;
    reg match;
    wire q_valid;
    wire q_take;
    wire [RW-1:0] q_data;

    eprg_fifo #(
        .WIDTH(RW),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_sel, req_data, req_addr}),
        .out_valid(q_valid),
        .out_ready(q_take),
        .out_data(q_data)
    );

    // back-pressure: sequencer takes a request only when idle
    assign q_take = (state == S_IDLE);

    // erased bits are one; a zero in the read byte where one is wanted can never recover
    function verify_ok;
        input [7:0] got;
        input [7:0] exp;
        begin
            verify_ok = (got == exp);
        end
    endfunction

    // a timed phase ends once its counter reaches the limit
    function reached;
        input [16:0] count;
        input [16:0] lim;
        begin
            reached = (count >= lim);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // ce low holds every register, so pins keep their level while frozen
    always @(posedge core_clk) begin
        if (!rstn) begin
            state <= S_IDLE;
            cnt <= 17'h00000;
            want <= 8'hff;
            match <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            tries <= 8'h00;
            busy <= 1'b0;
            mem_addr <= {ADDR_W{1'b0}};
            mem_data_out <= 8'hff;
            mem_data_oe <= 1'b0;
            chip_select_n <= {NDEV{1'b1}};
            output_gate_n <= 1'b1;
            write_pulse_n <= 1'b1;
            vpp_high <= 1'b0;
            vcc_prog <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            fail <= 1'b0;
            case (state)
                S_IDLE: begin
                    chip_select_n <= {NDEV{1'b1}};
                    output_gate_n <= 1'b1;
                    mem_data_oe <= 1'b0;
                    vpp_high <= 1'b0;
                    vcc_prog <= 1'b0;
                    busy <= 1'b0;
                    if (q_valid) begin
                        mem_addr <= q_data[ADDR_W-1:0];
                        mem_data_out <= q_data[ADDR_W+7:ADDR_W];
                        want <= q_data[ADDR_W+7:ADDR_W];
                        chip_select_n <= ~q_data[RW-1:ADDR_W+8];
                        mem_data_oe <= 1'b1;
                        vpp_high <= 1'b1;
                        vcc_prog <= 1'b1;
                        tries <= 8'h00;
                        busy <= 1'b1;
                        cnt <= 17'h00000;
                        state <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    // address, data, select and supplies settle before the pulse
                    if (reached(cnt, SETUP_C - 17'h00001)) begin
                        cnt <= 17'h00000;
                        write_pulse_n <= 1'b0;
                        tries <= tries + 8'h01;
                        state <= S_PULSE;
                    end else begin
                        cnt <= cnt + 17'h00001;
                    end
                end
                S_PULSE: begin
                    if (reached(cnt, PLS_C - 17'h00001)) begin
                        cnt <= 17'h00000;
                        write_pulse_n <= 1'b1;
                        state <= S_HOLD;
                    end else begin
                        cnt <= cnt + 17'h00001;
                    end
                end
                S_HOLD: begin
                    // data kept after the pulse; then the bus is released for the read
                    if (reached(cnt, HOLD_C - 17'h00001)) begin
                        cnt <= 17'h00000;
                        mem_data_oe <= 1'b0;
                        output_gate_n <= 1'b0;
                        state <= S_GATE;
                    end else begin
                        cnt <= cnt + 17'h00001;
                    end
                end
                S_GATE: begin
                    // margin check is inside the device; the host only compares
                    if (reached(cnt, ACC_C)) begin
                        cnt <= 17'h00000;
                        match <= verify_ok(mem_data_in, want);
                        output_gate_n <= 1'b1;
                        state <= S_FLOAT;
                    end else begin
                        cnt <= cnt + 17'h00001;
                    end
                end
                S_FLOAT: begin
                    // address held until the gate is high and outputs have floated
                    if (reached(cnt, FLT_C)) begin
                        cnt <= 17'h00000;
                        if (match) begin
                            done <= 1'b1;
                            state <= S_GAP;
                        end else if (tries >= TRY_LIM) begin
                            fail <= 1'b1;
                            state <= S_GAP;
                        end else begin
                            mem_data_oe <= 1'b1;
                            state <= S_SETUP;
                        end
                    end else begin
                        cnt <= cnt + 17'h00001;
                    end
                end
                S_GAP: begin
                    chip_select_n <= {NDEV{1'b1}};
                    vpp_high <= 1'b0;
                    vcc_prog <= 1'b0;
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ### tb/eprg_dev.sv
// Purpose: behavioural otp byte memory facing the sequencer
// Assumes: no clock; acts on pin edges and levels
// Notes: a byte reads erased until NEED pulses gave it margin
`timescale 1ns/1ps
module eprg_dev #(parameter NEED = 1) (
    // control
    input wire cs_n,
    input wire og_n,
    input wire wp_n,
    input wire vpp,
    input wire vcc,
    // address and data
    input wire [7:0] addr,
    input wire [7:0] d,
    output wire [7:0] q,
    output wire q_oe
);
    logic [7:0] mem [0:255];
    int cnt [0:255];
    initial for (int i = 0; i < 256; i++) begin
        mem[i] = 8'hff;
        cnt[i] = 0;
    end
    // shared pulse ignored while deselected
    always @(negedge wp_n) if (!cs_n && vpp && vcc) begin
        mem[addr] = mem[addr] & d;
        cnt[addr] = cnt[addr] + 1;
    end
    assign q = (cnt[addr] >= NEED) ? mem[addr] : 8'hff;
    assign q_oe = !cs_n && !og_n && wp_n && vpp;
endmodule

// ### tb/eprg_prog_sva.sv
// Purpose: port checks of the byte programming sequencer
// Assumes: ce high, so ages advance every cycle
// Notes: stab_age and high_age saturate so long idles never wrap
`timescale 1ns/1ps
`include "eprg_map.vh"
module eprg_prog_sva #(
    parameter ADDR_W = 17,
    parameter NDEV = 1,
    parameter MAX_TRIES = 25,
    parameter PULSE_CYC = 50
) (
    // clocking
    input wire core_clk,
    input wire rstn,
    // result
    input wire done,
    input wire fail,
    input wire [7:0] tries,
    // memory pins
    input wire [ADDR_W-1:0] mem_addr,
    input wire [7:0] mem_data_out,
    input wire mem_data_oe,
    input wire [NDEV-1:0] chip_select_n,
    input wire output_gate_n,
    input wire write_pulse_n,
    input wire vpp_high,
    input wire vcc_prog
);
    localparam int SETUP = `EPRG_SETUP_CYC;
    localparam int HOLD = `EPRG_HOLD_CYC;
    logic [15:0] stab_age, low_age, high_age;
    wire idle_cs = &chip_select_n;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////
    always @(posedge core_clk) begin
        if (!rstn) begin
            stab_age <= 16'h0;
            low_age <= 16'h0;
            high_age <= 16'hffff;
        end else begin
            stab_age <= ($changed(mem_addr) || $changed(mem_data_out) || $changed(mem_data_oe)
                || $changed(chip_select_n) || $changed(vpp_high)) ? 16'h0 : stab_age + {15'h0, ~&stab_age};
            low_age <= write_pulse_n ? 16'h0 : low_age + 16'h1;
            high_age <= $rose(write_pulse_n) ? 16'h0 : high_age + {15'h0, ~&high_age};
        end
    end
    ////////////////////////////////////////////////////////////
    a_setup_lead: assert property ($fell(write_pulse_n) |-> stab_age >= SETUP - 1)
        else $error("pulse fell too early");
    a_pulse_width: assert property ($rose(write_pulse_n) |-> low_age == PULSE_CYC)
        else $error("pulse width wrong");
    a_data_hold: assert property ($changed(mem_data_out) || $fell(mem_data_oe) |-> high_age >= HOLD - 1)
        else $error("data released too early");
    a_gate_lead: assert property ($fell(output_gate_n) |-> high_age >= HOLD - 1 && !mem_data_oe)
        else $error("gate low too early");
    a_verify_mode: assert property (!output_gate_n |-> $stable(mem_addr) && write_pulse_n && vpp_high && !idle_cs)
        else $error("verify conditions broken");
    a_prog_mode: assert property (!write_pulse_n |-> vpp_high && vcc_prog && output_gate_n && mem_data_oe && !idle_cs)
        else $error("pulse outside program mode");
    a_supply_order: assert property (vpp_high |-> vcc_prog)
        else $error("high supply without core supply");
    a_no_overpulse: assert property (done |=> write_pulse_n [*8])
        else $error("pulse after good verify");
    a_byte_release: assert property (done || fail |-> ##[1:2] (idle_cs && !vpp_high))
        else $error("part not released");
    a_try_limit: assert property (fail |-> tries == MAX_TRIES && !done)
        else $error("fail before try limit");
    c_pulse: cover property ($fell(write_pulse_n));
    c_verify: cover property ($fell(output_gate_n));
    c_done: cover property (done);
    c_fail: cover property (fail);
endmodule
bind eprg_prog eprg_prog_sva #(.ADDR_W(ADDR_W), .NDEV(NDEV), .MAX_TRIES(MAX_TRIES), .PULSE_CYC(PULSE_CYC)) u_eprg_prog_sva (
    .core_clk(core_clk), .rstn(rstn), .done(done), .fail(fail), .tries(tries), .mem_addr(mem_addr),
    .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .chip_select_n(chip_select_n),
    .output_gate_n(output_gate_n), .write_pulse_n(write_pulse_n), .vpp_high(vpp_high), .vcc_prog(vcc_prog));

// ### tb/tb_top.sv
// Purpose: self-checking bench of the byte programming sequencer
// Assumes: two parts share every pin but chip select
// Notes: short pulse parameter, so pulse width is nominal only
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic f; logic [7:0] t; logic [7:0] a; logic [7:0] m; logic [1:0] s;} eprg_note;
    logic core_clk = 0, rstn = 0, ce = 1, req_valid = 0, saw_full = 0;
    logic [7:0] req_addr = 0, req_data = 0, last_bus = 0, seed = 8'h55;
    logic [1:0] req_sel = 0;
    wire req_ready, done, fail, busy, mem_data_oe, output_gate_n, write_pulse_n, vpp_high, vcc_prog, oe0, oe1;
    wire [7:0] tries, mem_addr, mem_data_out, q0, q1, data_bus;
    wire [1:0] chip_select_n;
    int n_fail = 0, samples_checked = 0;
    eprg_note notes[$];
    always #2 core_clk = ~core_clk;
    // undriven pins show the inverse, never a stale byte
    assign data_bus = oe0 ? q0 : (oe1 ? q1 : (mem_data_oe ? mem_data_out : ~last_bus));
    always @(posedge core_clk) last_bus <= data_bus;
    eprg_prog #(.ADDR_W(8), .NDEV(2), .MAX_TRIES(3), .PULSE_CYC(50)) u_eprg_prog (.core_clk(core_clk), .rstn(rstn),
        .ce(ce), .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_data(req_data),
        .req_sel(req_sel), .done(done), .fail(fail), .tries(tries), .busy(busy), .mem_addr(mem_addr),
        .mem_data_out(mem_data_out), .mem_data_oe(mem_data_oe), .mem_data_in(data_bus), .chip_select_n(chip_select_n),
        .output_gate_n(output_gate_n), .write_pulse_n(write_pulse_n), .vpp_high(vpp_high), .vcc_prog(vcc_prog));
    eprg_dev #(.NEED(2)) u_eprg_dev0 (.cs_n(chip_select_n[0]), .og_n(output_gate_n), .wp_n(write_pulse_n),
        .vpp(vpp_high), .vcc(vcc_prog), .addr(mem_addr), .d(data_bus), .q(q0), .q_oe(oe0));
    eprg_dev u_eprg_dev1 (.cs_n(chip_select_n[1]), .og_n(output_gate_n), .wp_n(write_pulse_n),
        .vpp(vpp_high), .vcc(vcc_prog), .addr(mem_addr), .d(data_bus), .q(q1), .q_oe(oe1));
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic send(input logic [7:0] a, d, input logic [1:0] s, input logic f, input logic [7:0] t, m);
        logic rdy;
        int n;
        n = 0;
        notes.push_back('{f, t, a, m, s});
        req_valid <= 1'b1;
        req_addr <= a;
        req_data <= d;
        req_sel <= s;
        do begin
            @(negedge core_clk);
            rdy = req_ready;
            if (rdy !== 1'b1) saw_full = 1'b1;
            @(posedge core_clk);
            n++;
            if (n > 40000) begin
                check(1'b0, "send timeout");
                complete_run();
            end
        end while (rdy !== 1'b1);
    endtask
    task automatic drain();
        int n;
        n = 0;
        req_valid <= 1'b0;
        while (notes.size() > 0 || busy !== 1'b0) begin
            @(negedge core_clk);
            n++;
            if (n > 40000) begin
                check(1'b0, "drain timeout");
                complete_run();
            end
        end
        @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge core_clk) if (rstn && (done === 1'b1 || fail === 1'b1)) begin
        eprg_note e;
        if (notes.size() == 0) check(1'b0, "result without request");
        else begin
            e = notes.pop_front();
            check(fail === e.f && tries === e.t, "result or tries");
            check((e.s[0] ? u_eprg_dev0.mem[e.a] : u_eprg_dev1.mem[e.a]) === e.m, "stored byte");
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        check(busy === 1'b0 && req_ready === 1'b1 && chip_select_n === 2'b11 && vpp_high === 1'b0, "reset");
        // seven requests: one in the sequencer, one in the output register, four queued, one refused
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            send(8'h10 + i[7:0], seed, 2'b01, 1'b0, 8'h02, seed);
        end
        drain();
        check(saw_full === 1'b1 && req_ready === 1'b1, "fifo fill and drain");
        $display("test burst done");
        // frozen block must refuse a request and take nothing
        ce <= 1'b0;
        req_valid <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(req_ready === 1'b0 && busy === 1'b0 && chip_select_n === 2'b11, "frozen block took request");
        ce <= 1'b1;
        req_valid <= 1'b0;
        seed = lfsr(seed);
        send(8'h20, seed, 2'b10, 1'b0, 8'h01, seed);
        drain();
        check(u_eprg_dev0.mem[8'h20] === 8'hff, "deselected part written");
        $display("test inhibit done");
        send(8'h05, 8'h00, 2'b01, 1'b0, 8'h02, 8'h00);
        send(8'h05, 8'h5a, 2'b01, 1'b1, 8'h03, 8'h00);
        drain();
        check(chip_select_n === 2'b11 && write_pulse_n === 1'b1 && vpp_high === 1'b0, "idle pins");
        $display("test limit done");
        complete_run();
    end
endmodule
